/* File: rtl/asf_sample_fifo.sv */
// thirty-two entry acceleration sample buffer with its register bank and link side
//
// Overview of operation
// - status register holds overflow bit 7, level bit 6, count bits 5..0.
// - overflow flag set while stored count equals thirty-two.
// - flags follow their causes; status read clears only buffer interrupt source.
// - level flag set when count reaches threshold, held while above it.
// - threshold zero never raises the level flag.
// - count reads zero when empty or after reset, else one to thirty-two.
// - byte port returns X, Y, Z upper bytes, oldest sample first.
// - reads past the stored samples return zero bytes.
// - wide port returns low then high byte per axis, low nibble only.
// - with redirect on, other output data addresses read zero.
// - no samples stored from the first buffer read until STOP; a new address does not release it.
// - reading a sample removes the oldest and decrements the count.
// - policy 00 off, 01 circular overwrite, 10 stop when full, 11 unused.
// - flush on disable, automatic rate change with the gate off, and standby to active.
// - writing the off policy clears flags and count.
// - count above threshold never blocks acceptance.
// - samples arrive at the active or sleep rate chosen upstream.
// - capacity thirty-two samples; threshold spans up to capacity.
// - redirect bit in data configuration maps output addresses to buffer, resets 0.
// - interrupt source set on overflow or count equal threshold when enabled.
// - gate error set if buffer not emptied before next sample, cleared on empty.
`timescale 1ns/1ns
`include "asf_params.svh"
module asf_sample_fifo #(
	parameter int DEPTH = 32
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic link_clk,
	input wire logic link_rst_b,
	input wire logic sample_stb,
	input wire asf_pkg::asf_sample_type sample_in,
	input wire logic active_mode,
	input wire logic rate_change_stb,
	input wire logic gate_enable,
	input wire logic fifo_irq_enable,
	input wire logic lk_cmd_valid,
	input wire asf_pkg::asf_cmd_type lk_cmd,
	output logic lk_cmd_ready,
	output logic lk_rsp_valid,
	output logic [7:0] lk_rsp_data,
	output logic overflow_flag,
	output logic level_reached_flag,
	output logic buffer_irq_source,
	output logic gate_overrun_error,
	output logic output_redirect
);
	import asf_pkg::*;
	localparam int PW = $clog2(DEPTH);
	// capacity, threshold spans up to it
	localparam logic [5:0] FULL = 6'(DEPTH);

	// ****************************************
	// link side: hold one command, hand it over by toggle
	// ****************************************
	asf_lk_state_type lk_state_r;
	asf_cmd_type lk_hold_r;
	logic lk_req_tgl_r;
	logic [2:0] lk_ack_sync_r;
	logic lk_ack_seen_r;
	logic ack_tgl_r;
	logic [7:0] rsp_data_r;
	wire lk_take = lk_cmd_valid && lk_cmd_ready;
	wire lk_ack_new = (lk_ack_sync_r[1] == lk_ack_sync_r[2]) && (lk_ack_sync_r[2] != lk_ack_seen_r);

	always_ff @(posedge link_clk) begin
		lk_ack_sync_r <= {lk_ack_sync_r[1:0], ack_tgl_r};
		if (!link_rst_b) begin
			lk_state_r <= ASF_LK_IDLE;
			lk_hold_r <= '0;
			lk_req_tgl_r <= 1'b0;
			lk_ack_seen_r <= 1'b0;
			lk_ack_sync_r <= 3'h0;
			lk_cmd_ready <= 1'b0;
			lk_rsp_valid <= 1'b0;
			lk_rsp_data <= 8'h00;
		end else begin
			lk_rsp_valid <= 1'b0;
			case (lk_state_r)
				ASF_LK_IDLE: begin
					lk_cmd_ready <= 1'b1;
					if (lk_take) begin
						lk_hold_r <= lk_cmd;
						lk_req_tgl_r <= ~lk_req_tgl_r;
						lk_cmd_ready <= 1'b0;
						lk_state_r <= ASF_LK_WAIT;
					end
				end
				ASF_LK_WAIT: begin
					if (lk_ack_new) begin
						// answer word is stable once the ack toggle is seen
						lk_ack_seen_r <= lk_ack_sync_r[2];
						lk_rsp_data <= rsp_data_r;
						lk_rsp_valid <= (lk_hold_r.kind == ASF_CMD_READ);
						lk_state_r <= ASF_LK_DONE;
					end
				end
				ASF_LK_DONE: begin
					lk_cmd_ready <= 1'b1;
					lk_state_r <= ASF_LK_IDLE;
				end
				default: lk_state_r <= ASF_LK_IDLE;
			endcase
		end
	end

	// ****************************************
	// core side: catch the request toggle
	// ****************************************
	logic [2:0] req_sync_r;
	logic req_seen_r;
	wire req_new = (req_sync_r[1] == req_sync_r[2]) && (req_sync_r[2] != req_seen_r);
	wire asf_cmd_type cmd = lk_hold_r;
	wire cmd_addr = req_new && (cmd.kind == ASF_CMD_ADDR);
	wire cmd_wr = req_new && (cmd.kind == ASF_CMD_WRITE);
	wire cmd_rd = req_new && (cmd.kind == ASF_CMD_READ);
	wire cmd_stop = req_new && (cmd.kind == ASF_CMD_STOP);

	// ****************************************
	// register state
	// ****************************************
	asf_sample_type mem [0:DEPTH-1];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [5:0] count_r;
	logic [2:0] byte_idx_r;
	logic [7:0] addr_r;
	asf_mode_type mode_r;
	logic [5:0] thr_r;
	logic read_hold_r;
	logic active_d_r;
	logic event_d_r;

	wire full = (count_r == FULL);
	wire empty = (count_r == 6'h00);
	wire is_bport = (addr_r == `ASF_ADDR_BYTE_PORT) ||
		(output_redirect && addr_r == `ASF_ADDR_XMSB);
	wire is_wport = (addr_r == `ASF_ADDR_WIDE_PORT) ||
		(output_redirect && addr_r == `ASF_ADDR_XLSB);
	wire is_port = is_bport || is_wport;
	wire [2:0] last_idx = is_wport ? `ASF_BYTES_WIDE - 3'h1 : `ASF_BYTES_NARROW - 3'h1;
	// sample leaves after its final byte
	wire pop = cmd_rd && is_port && !empty && (byte_idx_r == last_idx);

	// flush causes; a gated buffer keeps data across a rate change
	wire activate = active_mode && !active_d_r;
	wire flush = (mode_r == ASF_MODE_OFF) || (rate_change_stb && !gate_enable) || activate;
	// acceptance by policy only, none while a read is open
	wire mode_on = (mode_r == ASF_MODE_CIRC) || (mode_r == ASF_MODE_STOP);
	// strobe paced upstream at active or sleep rate
	wire push = sample_stb && !read_hold_r && mode_on && !flush &&
		(!full || pop || mode_r == ASF_MODE_CIRC);
	wire overwrite = push && full && !pop;

	logic [5:0] count_nxt;
	always_comb begin
		count_nxt = count_r;
		if (flush) begin
			count_nxt = 6'h00;
		end else if (push && !pop && !overwrite) begin
			count_nxt = count_r + 6'h1;
		end else if (pop && !push) begin
			count_nxt = count_r - 6'h1;
		end
	end

	wire ovf_nxt = (count_nxt == FULL);
	wire lvl_nxt = (thr_r != 6'h00) && (count_nxt >= thr_r);
	wire lvl_eq = (thr_r != 6'h00) && (count_r == thr_r);
	wire irq_event = full || lvl_eq;

	// ****************************************
	// read data selection
	// ****************************************
	wire asf_sample_type head = mem[rd_ptr_r];
	wire [1:0] axis = is_wport ? 2'(byte_idx_r >> 1) : byte_idx_r[1:0];
	wire [11:0] axis_val = (axis == 2'h0) ? head.x : (axis == 2'h1) ? head.y : head.z;
	// upper byte, low nibble padded with zeros then high byte
	wire [7:0] port_byte = (is_wport && !byte_idx_r[0]) ? {4'h0, axis_val[3:0]} :
		axis_val[11:4];
	wire [7:0] status_byte = {overflow_flag, level_reached_flag, count_r};
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		if (is_port) begin
			rd_byte = empty ? 8'h00 : port_byte;
		end else begin
			// other output addresses fall through to zero
			case (addr_r)
				`ASF_ADDR_STATE: rd_byte = status_byte;
				`ASF_ADDR_CONFIG: rd_byte = {mode_r, thr_r};
				`ASF_ADDR_SYSMODE: rd_byte = {1'b0, gate_overrun_error, 6'h00};
				`ASF_ADDR_IRQ_SRC: rd_byte = {1'b0, buffer_irq_source, 6'h00};
				`ASF_ADDR_DATA_CFG: rd_byte = {output_redirect, 7'h00};
				default: rd_byte = 8'h00;
			endcase
		end
	end
	// data ports hold the address, others step on
	wire [7:0] addr_step = is_port ? addr_r : addr_r + 8'h1;

	// ****************************************
	// core registers
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ptr_r] <= sample_in;
		end
	end

	always_ff @(posedge ref_clk) begin
		req_sync_r <= {req_sync_r[1:0], lk_req_tgl_r};
		if (!rst_b) begin
			req_sync_r <= 3'h0;
			req_seen_r <= 1'b0;
			ack_tgl_r <= 1'b0;
			rsp_data_r <= 8'h00;
			addr_r <= 8'h00;
		end else if (req_new) begin
			req_seen_r <= req_sync_r[2];
			ack_tgl_r <= ~ack_tgl_r;
			rsp_data_r <= cmd_rd ? rd_byte : 8'h00;
			if (cmd_addr) begin
				addr_r <= cmd.data;
			end else if (cmd_wr || cmd_rd) begin
				addr_r <= addr_step;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= 6'h00;
			byte_idx_r <= 3'h0;
			overflow_flag <= 1'b0;
			level_reached_flag <= 1'b0;
			active_d_r <= 1'b0;
		end else begin
			active_d_r <= active_mode;
			count_r <= count_nxt;
			overflow_flag <= ovf_nxt;
			level_reached_flag <= lvl_nxt;
			if (flush) begin
				wr_ptr_r <= '0;
				rd_ptr_r <= '0;
				byte_idx_r <= 3'h0;
			end else begin
				if (push) begin
					wr_ptr_r <= PW'(wr_ptr_r + 1'b1);
				end
				// circular policy drops the oldest when full
				if (pop || overwrite) begin
					rd_ptr_r <= PW'(rd_ptr_r + 1'b1);
				end
				if (pop || cmd_stop) begin
					byte_idx_r <= 3'h0;
				end else if (cmd_rd && is_port && !empty) begin
					byte_idx_r <= byte_idx_r + 3'h1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			mode_r <= asf_mode_type'(2'(`ASF_CONFIG_RST >> `ASF_MODE_LO));
			thr_r <= 6'h00;
			output_redirect <= `ASF_DATA_CFG_RST;
			read_hold_r <= 1'b0;
		end else begin
			if (cmd_wr && addr_r == `ASF_ADDR_CONFIG) begin
				mode_r <= asf_mode_type'(cmd.data[`ASF_MODE_HI:`ASF_MODE_LO]);
				thr_r <= cmd.data[`ASF_THR_HI:`ASF_THR_LO];
			end
			if (cmd_wr && addr_r == `ASF_ADDR_DATA_CFG) begin
				output_redirect <= cmd.data[`ASF_REDIRECT_BIT];
			end
			// hold stores from first port read until STOP
			if (cmd_stop) begin
				read_hold_r <= 1'b0;
			end else if (cmd_rd && is_port) begin
				read_hold_r <= 1'b1;
			end
		end
	end

	// rising event sets source; status read clears, set wins
	wire stat_rd = cmd_rd && (addr_r == `ASF_ADDR_STATE);
	wire irq_set = fifo_irq_enable && irq_event && !event_d_r;
	// sample arriving on an unemptied gated buffer
	wire gerr_set = gate_enable && sample_stb && !empty;
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			event_d_r <= 1'b0;
			buffer_irq_source <= 1'b0;
			gate_overrun_error <= 1'b0;
		end else begin
			event_d_r <= irq_event;
			if (irq_set) begin
				buffer_irq_source <= 1'b1;
			end else if (stat_rd) begin
				buffer_irq_source <= 1'b0;
			end
			if (gerr_set) begin
				gate_overrun_error <= 1'b1;
			end else if (empty) begin
				gate_overrun_error <= 1'b0;
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence s_last_read;
		pop && !push && !flush;
	endsequence
	sequence s_disable_write;
		cmd_wr && addr_r == `ASF_ADDR_CONFIG && cmd.data[7:6] == 2'h0;
	endsequence

	a_count_range:
	assert property (@(posedge ref_clk) disable iff (!rst_b) count_r <= FULL)
		else $error("stored count above capacity");
	a_overflow_tracks:
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		##1 overflow_flag == (count_r == FULL))
		else $error("overflow flag disagrees with count");
	a_level_off:
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		thr_r == 6'h00 && $past(thr_r) == 6'h00 |-> !level_reached_flag)
		else $error("level flag with zero threshold");
	a_disable_clears:
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_disable_write |-> ##2 count_r == 6'h00 && !overflow_flag && !level_reached_flag)
		else $error("off policy did not clear buffer");
	a_hold_blocks:
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		read_hold_r && !pop |=> count_r <= $past(count_r))
		else $error("sample stored during buffer read");
	a_pop_decrements:
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_last_read |=> count_r == $past(count_r) - 6'h1)
		else $error("read did not remove a sample");
	a_empty_reads_zero:
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_rd && is_port && empty |=> rsp_data_r == 8'h00)
		else $error("empty buffer returned data");
	a_irq_source_set:
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		irq_set |=> buffer_irq_source)
		else $error("buffer interrupt source not set");
	a_stop_policy:
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		mode_r == ASF_MODE_STOP && full && !pop && !flush |=> count_r == FULL &&
		wr_ptr_r == $past(wr_ptr_r))
		else $error("stop policy accepted a sample when full");
	a_gate_clear:
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		(empty && !gerr_set) [*2] |-> ##1 !gate_overrun_error)
		else $error("gate error stayed after emptying");
endmodule

/* File: pkg/asf_params.svh */
// register offsets, field positions and reset values of the sample buffer
`ifndef ASF_PARAMS_SVH
`define ASF_PARAMS_SVH
`define ASF_ADDR_XMSB 8'h01
`define ASF_ADDR_YMSB 8'h02
`define ASF_ADDR_ZMSB 8'h03
`define ASF_ADDR_XLSB 8'h05
`define ASF_ADDR_ZMSB12 8'h0a
`define ASF_ADDR_STATE 8'h10
`define ASF_ADDR_BYTE_PORT 8'h11
`define ASF_ADDR_WIDE_PORT 8'h12
`define ASF_ADDR_CONFIG 8'h13
`define ASF_ADDR_SYSMODE 8'h14
`define ASF_ADDR_IRQ_SRC 8'h15
`define ASF_ADDR_DATA_CFG 8'h16
`define ASF_OVF_BIT 7
`define ASF_LVL_BIT 6
`define ASF_MODE_HI 7
`define ASF_MODE_LO 6
`define ASF_THR_HI 5
`define ASF_THR_LO 0
`define ASF_GATE_ERR_BIT 6
`define ASF_IRQ_SRC_BIT 6
`define ASF_REDIRECT_BIT 7
`define ASF_CONFIG_RST 8'h00
`define ASF_DATA_CFG_RST 1'b0
`define ASF_BYTES_NARROW 3'h3
`define ASF_BYTES_WIDE 3'h6
`endif

/* File: pkg/asf_pkg.sv */
// types shared by the sample buffer and its link side
package asf_pkg;
	typedef enum logic [1:0] {
		ASF_MODE_OFF = 2'h0,
		ASF_MODE_CIRC = 2'h1,
		ASF_MODE_STOP = 2'h2,
		ASF_MODE_NONE = 2'h3
	} asf_mode_type;
	typedef enum logic [1:0] {
		ASF_CMD_ADDR = 2'h0,
		ASF_CMD_WRITE = 2'h1,
		ASF_CMD_READ = 2'h2,
		ASF_CMD_STOP = 2'h3
	} asf_cmd_kind_type;
	typedef struct packed {
		asf_cmd_kind_type kind;
		logic [7:0] data;
	} asf_cmd_type;
	typedef struct packed {
		logic [11:0] x;
		logic [11:0] y;
		logic [11:0] z;
	} asf_sample_type;
	typedef enum logic [1:0] {
		ASF_LK_IDLE = 2'h0,
		ASF_LK_WAIT = 2'h1,
		ASF_LK_DONE = 2'h3
	} asf_lk_state_type;
endpackage

/* File: tb/asf_link_host.sv */
// link-side host model issuing register commands toward the sample buffer
`timescale 1ns/1ns
module asf_link_host (
	input wire logic link_clk,
	input wire logic lk_cmd_ready,
	input wire logic lk_rsp_valid,
	input wire logic [7:0] lk_rsp_data,
	output asf_pkg::asf_cmd_type lk_cmd,
	output logic lk_cmd_valid,
	output logic timed_out
);
	import asf_pkg::*;
	initial begin
		lk_cmd_valid = 1'b0;
		lk_cmd = '{ASF_CMD_STOP, 8'h00};
		timed_out = 1'b0;
	end
	// one command in flight: wait until the bank is ready again
	task automatic wait_ready();
		int n = 0;
		@(negedge link_clk);
		while (lk_cmd_ready !== 1'b1 && n < 100) begin
			@(negedge link_clk);
			n++;
		end
		if (n >= 100) timed_out = 1'b1;
	endtask
	task automatic cmd(input asf_cmd_kind_type k, input logic [7:0] d);
		wait_ready();
		lk_cmd_valid = 1'b1;
		lk_cmd = '{k, d};
		@(posedge link_clk);
		lk_cmd_valid <= 1'b0;
		// released command shows inverted data so stale values cannot pass
		lk_cmd <= '{ASF_CMD_ADDR, ~d};
	endtask
	task automatic get(output logic [7:0] d);
		int n = 0;
		cmd(ASF_CMD_READ, 8'h00);
		@(negedge link_clk);
		while (lk_rsp_valid !== 1'b1 && n < 40) begin
			@(negedge link_clk);
			n++;
		end
		if (n >= 40) timed_out = 1'b1;
		d = lk_rsp_data;
	endtask
endmodule

/* File: tb/asf_sample_fifo_tb_top.sv */
// self-checking bench for the acceleration sample buffer
`timescale 1ns/1ns
`include "asf_params.svh"
`define CHK(nm, ex, got) \
	begin \
		comparisons++; \
		if ((got) !== (ex)) begin \
			errors++; \
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
		end \
	end
module asf_sample_fifo_tb_top;
	import asf_pkg::*;
	localparam logic [7:0] A_ST = `ASF_ADDR_STATE;
	localparam logic [7:0] A_CF = `ASF_ADDR_CONFIG;
	localparam logic [7:0] A_BP = `ASF_ADDR_BYTE_PORT;
	localparam logic [7:0] A_WP = `ASF_ADDR_WIDE_PORT;
	localparam logic [7:0] A_DC = `ASF_ADDR_DATA_CFG;
	logic ref_clk, rst_b, link_clk, link_rst_b, sample_stb, active_mode, rate_change_stb;
	logic gate_enable, fifo_irq_enable, lk_cmd_valid, lk_cmd_ready, lk_rsp_valid, timed_out;
	logic overflow_flag, level_reached_flag, buffer_irq_source, gate_overrun_error;
	logic output_redirect;
	logic [7:0] lk_rsp_data, d;
	asf_cmd_type lk_cmd;
	asf_sample_type sample_in;
	int errors = 0;
	int comparisons = 0;
	int cycles = 0;
	asf_sample_fifo DUT (.ref_clk, .rst_b, .link_clk, .link_rst_b, .sample_stb, .sample_in,
		.active_mode, .rate_change_stb, .gate_enable, .fifo_irq_enable, .lk_cmd_valid, .lk_cmd,
		.lk_cmd_ready, .lk_rsp_valid, .lk_rsp_data, .overflow_flag, .level_reached_flag,
		.buffer_irq_source, .gate_overrun_error, .output_redirect);
	asf_link_host host (.link_clk, .lk_cmd_ready, .lk_rsp_valid, .lk_rsp_data, .lk_cmd,
		.lk_cmd_valid, .timed_out);
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// link clock deliberately offset so edges never line up
	initial begin
		link_clk = 1'b0;
		#7;
		forever #24 link_clk = ~link_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			finish_test();
		end
	end
	// ****************************************
	// helpers
	// ****************************************
	function automatic asf_sample_type mk(input int i);
		return '{{8'(i), 4'h5}, {8'(i + 64), 4'ha}, {8'(i + 128), 4'hc}};
	endfunction
	function automatic logic [7:0] nb(input int i, input int k);
		return 8'(i + 64 * k);
	endfunction
	function automatic logic [7:0] wb(input int i, input int j);
		return (j % 2) ? nb(i, j / 2) : {4'h0, (j == 0) ? 4'h5 : (j == 2) ? 4'ha : 4'hc};
	endfunction
	task automatic fill(input int i0, input int n);
		for (int k = 0; k < n; k++) begin
			@(negedge ref_clk);
			sample_stb = 1'b1;
			sample_in = mk(i0 + k);
			@(negedge ref_clk);
			sample_stb = 1'b0;
		end
	endtask
	task automatic stop_bus();
		host.cmd(ASF_CMD_STOP, 8'h00);
		host.wait_ready();
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		host.cmd(ASF_CMD_ADDR, a);
		host.cmd(ASF_CMD_WRITE, v);
		stop_bus();
	endtask
	task automatic rdb(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		host.cmd(ASF_CMD_ADDR, a);
		host.get(v);
		stop_bus();
		`CHK($sformatf("reg %h", a), e, v)
	endtask
	// bytes past avl must read as zero
	task automatic burst(input logic [7:0] a, input int i0, input int n, input int avl,
		input bit w);
		logic [7:0] v, e;
		host.cmd(ASF_CMD_ADDR, a);
		for (int b = 0; b < n; b++) begin
			host.get(v);
			e = (b >= avl) ? 8'h00 : w ? wb(i0 + b / 6, b % 6) : nb(i0 + b / 3, b % 3);
			`CHK("sample byte", e, v)
		end
		stop_bus();
	endtask
	task automatic pulse_rate();
		@(negedge ref_clk);
		rate_change_stb = 1'b1;
		@(negedge ref_clk);
		rate_change_stb = 1'b0;
	endtask
	task automatic set_active(input logic v);
		@(negedge ref_clk);
		active_mode = v;
		repeat (2) @(negedge ref_clk);
	endtask
	task automatic finish_test();
		if (errors == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rst_b = 1'b0;
		link_rst_b = 1'b0;
		sample_stb = 1'b0;
		sample_in = '0;
		active_mode = 1'b0;
		rate_change_stb = 1'b0;
		gate_enable = 1'b0;
		fifo_irq_enable = 1'b1;
		repeat (20) @(negedge ref_clk);
		rst_b = 1'b1;
		link_rst_b = 1'b1;
		rdb(A_ST, 8'h00);
		rdb(A_CF, 8'h00);
		rdb(A_DC, 8'h00);
		rdb(8'h20, 8'h00);
		// threshold set while in standby
		wr(A_CF, 8'h43);
		rdb(A_CF, 8'h43);
		set_active(1'b1);
		fill(0, 2);
		`CHK("level flag", 1'b0, level_reached_flag)
		fill(2, 1);
		`CHK("level flag", 1'b1, level_reached_flag)
		// source follows the registered count by one edge
		@(negedge ref_clk);
		`CHK("irq source", 1'b1, buffer_irq_source)
		rdb(A_ST, 8'h43);
		`CHK("irq source", 1'b0, buffer_irq_source)
		`CHK("level flag", 1'b1, level_reached_flag)
		burst(A_BP, 0, 3, 3, 1'b0);
		rdb(A_ST, 8'h02);
		burst(A_WP, 1, 13, 12, 1'b1);
		rdb(A_ST, 8'h00);
		fill(3, 2);
		host.cmd(ASF_CMD_ADDR, A_BP);
		host.get(d);
		fill(5, 1);
		stop_bus();
		`CHK("held byte", nb(3, 0), d)
		rdb(A_ST, 8'h02);
		burst(A_BP, 3, 7, 6, 1'b0);
		fill(0, 33);
		rdb(A_ST, 8'he0);
		burst(A_BP, 1, 1, 3, 1'b0);
		burst(A_BP, 1, 3, 3, 1'b0);
		`CHK("overflow flag", 1'b0, overflow_flag)
		fifo_irq_enable = 1'b0;
		set_active(1'b0);
		// policy switch passes through the off value
		wr(A_CF, 8'h00);
		rdb(A_ST, 8'h00);
		wr(A_CF, 8'h80);
		set_active(1'b1);
		fill(0, 33);
		`CHK("irq source", 1'b0, buffer_irq_source)
		rdb(A_ST, 8'ha0);
		burst(A_BP, 0, 1, 3, 1'b0);
		wr(A_DC, 8'h80);
		`CHK("redirect", 1'b1, output_redirect)
		rdb(8'h02, 8'h00);
		rdb(8'h0a, 8'h00);
		burst(8'h01, 0, 2, 3, 1'b0);
		pulse_rate();
		rdb(A_ST, 8'h00);
		fill(0, 1);
		set_active(1'b0);
		set_active(1'b1);
		rdb(A_ST, 8'h00);
		gate_enable = 1'b1;
		fill(0, 2);
		`CHK("gate error", 1'b1, gate_overrun_error)
		pulse_rate();
		rdb(A_ST, 8'h02);
		burst(8'h05, 0, 13, 12, 1'b1);
		`CHK("gate error", 1'b0, gate_overrun_error)
		wr(A_CF, 8'h00);
		wr(A_CF, 8'hc0);
		fill(0, 1);
		rdb(A_ST, 8'h00);
		`CHK("host timeout", 1'b0, timed_out)
		finish_test();
	end
endmodule
